// >>> sbp_basic_param_table.sv
// Top of the basic flash parameter table block with APB register access
//
// What this block does
// R1 - Table starts at discovery address 1090h
// R2 - Density zero based, 03FFFFFFh, LSB first
// R3 - Quad I/O: EBh, mode 010b, dummy 01000b
// R4 - Quad output: 6Bh, mode 000b, dummy 01000b
// R5 - Dual output: 3Bh, mode 000b, dummy 01000b
// R6 - Dual I/O: BBh, mode 100b, dummy 01000b
// R7 - Dummy counts are factory default latency
// R8 - Four-wire command mode support bit reads 1
// R9 - Dual-all unsupported, its fields all ones
// R10 - Reserved bits in dwords five, six read ones
// R11 - Each byte also at legacy offset plus two
`timescale 1ns/100ps

module sbp_basic_param_table (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata
);

    typedef struct packed {
        logic [15:0] byte_addr;
    } sbp_top_state_t;

    sbp_top_state_t            state_reg;
    sbp_top_state_t            state_next;
    sbp_pkg::sbp_apb_req_t     apb_req;
    sbp_pkg::sbp_apb_rsp_t     apb_rsp;
    sbp_pkg::sbp_lookup_req_t  lookup_req;
    sbp_pkg::sbp_lookup_rsp_t  lookup_rsp;
    logic                      write_strobe;
    logic [31:0]               density_word;
    logic [31:0]               quad_word;
    logic [31:0]               dual_word;
    logic [31:0]               mode_word;
    logic [31:0]               dual_all_word;
    logic [31:0]               read_word;
    logic                      read_valid;

    assign apb_req = '{psel: psel, penable: penable, pwrite: pwrite,
                       paddr: paddr, pwdata: pwdata};

    // Byte pointer into the discovery space steers the byte lookup
    assign lookup_req.addr = state_reg.byte_addr;  // see R1, see R11

    sbp_table_rom u_rom (
        .clock         (clock),
        .nrst          (nrst),
        .req           (lookup_req),
        .rsp           (lookup_rsp),
        .density_word  (density_word),   // see R2
        .quad_word     (quad_word),      // see R3, see R4, see R7
        .dual_word     (dual_word),      // see R5, see R6, see R7
        .mode_word     (mode_word),      // see R8, see R10
        .dual_all_word (dual_all_word)   // see R9, see R10
    );

    sbp_apb_if u_apb (
        .clock        (clock),
        .nrst         (nrst),
        .req          (apb_req),
        .read_word    (read_word),
        .read_valid   (read_valid),
        .write_strobe (write_strobe),
        .rsp          (apb_rsp)
    );

    // Read decode; unmapped addresses answer with an error and zero data
    always_comb
    begin
        read_valid = 1'b1;
        if (paddr == sbp_pkg::DENSITY_OFFS)
            read_word = density_word;
        else if (paddr == sbp_pkg::QUAD_RD_OFFS)
            read_word = quad_word;
        else if (paddr == sbp_pkg::DUAL_RD_OFFS)
            read_word = dual_word;
        else if (paddr == sbp_pkg::MODE_SUP_OFFS)
            read_word = mode_word;
        else if (paddr == sbp_pkg::DUAL_ALL_OFFS)
            read_word = dual_all_word;
        else if (paddr == sbp_pkg::BYTE_ADDR_OFFS)
            read_word = {16'h0000, state_reg.byte_addr};
        else if (paddr == sbp_pkg::BYTE_DATA_OFFS)
            read_word = {23'h000000, lookup_rsp.hit, lookup_rsp.data};
        else
        begin
            read_word  = sbp_pkg::ZERO_WORD;
            read_valid = 1'b0;
        end
        // Table words are read only; writing them is an error
        if (pwrite && paddr != sbp_pkg::BYTE_ADDR_OFFS)
            read_valid = 1'b0;
    end

    // Pointer register: the only writable location
    always_comb
    begin
        state_next = state_reg;
        if (write_strobe && paddr == sbp_pkg::BYTE_ADDR_OFFS)
            state_next.byte_addr = pwdata[15:0];
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_reg.byte_addr <= sbp_pkg::BYTE_ADDR_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign pready  = apb_rsp.pready;
    assign pslverr = apb_rsp.pslverr;
    assign prdata  = apb_rsp.prdata;

endmodule // sbp_basic_param_table

// >>> sbp_pkg.sv
// Package with the parameter table layout, register offsets and bus carriers
package sbp_pkg;

    // APB register byte offsets
    localparam logic [11:0] DENSITY_OFFS   = 12'h004;
    localparam logic [11:0] QUAD_RD_OFFS   = 12'h008;
    localparam logic [11:0] DUAL_RD_OFFS   = 12'h00C;
    localparam logic [11:0] MODE_SUP_OFFS  = 12'h010;
    localparam logic [11:0] DUAL_ALL_OFFS  = 12'h014;
    localparam logic [11:0] BYTE_ADDR_OFFS = 12'h018;
    localparam logic [11:0] BYTE_DATA_OFFS = 12'h01C;

    // Discovery space placement of the table
    localparam logic [15:0] TABLE_BASE     = 16'h1090;
    localparam logic [15:0] LEGACY_BASE    = 16'h108E;
    localparam logic [15:0] LEGACY_SHIFT   = 16'h0002;
    localparam logic [4:0]  TABLE_FIRST    = 5'h04;
    localparam logic [4:0]  TABLE_LAST     = 5'h17;

    // Density: zero based bit count of a 64 Mb part
    localparam logic [31:0] DENSITY_BITS   = 32'h03FFFFFF;

    // Read descriptors
    localparam logic [7:0]  QUAD_IO_OP     = 8'hEB;
    localparam logic [2:0]  QUAD_IO_MODE   = 3'h2;
    localparam logic [7:0]  QUAD_OUT_OP    = 8'h6B;
    localparam logic [2:0]  QUAD_OUT_MODE  = 3'h0;
    localparam logic [7:0]  DUAL_OUT_OP    = 8'h3B;
    localparam logic [2:0]  DUAL_OUT_MODE  = 3'h0;
    localparam logic [7:0]  DUAL_IO_OP     = 8'hBB;
    localparam logic [2:0]  DUAL_IO_MODE   = 3'h4;
    localparam logic [4:0]  DEFAULT_DUMMY  = 5'h08;
    localparam logic [4:0]  PLAIN_DUMMY    = 5'h08;

    // Mode support and dual-all fill
    localparam logic        FOUR_WIRE_OK   = 1'h1;
    localparam logic        DUAL_ALL_OK    = 1'h0;
    localparam logic [2:0]  RSV3           = 3'h7;
    localparam logic [7:0]  RSV8           = 8'hFF;
    localparam logic [2:0]  DUAL_ALL_MODE  = 3'h7;
    localparam logic [4:0]  DUAL_ALL_DUMMY = 5'h1F;
    localparam logic [7:0]  DUAL_ALL_OP    = 8'hFF;

    // Reset values
    localparam logic [15:0] BYTE_ADDR_RST  = 16'h1094;
    localparam logic [31:0] ZERO_WORD      = 32'h00000000;

    // Mode cycles in bits 7:5, dummy cycles in bits 4:0
    typedef struct packed {
        logic [2:0] mode_cycles;
        logic [4:0] dummy_cycles;
    } sbp_latency_t;

    // APB request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sbp_apb_req_t;

    // APB answer
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sbp_apb_rsp_t;

    // Byte lookup request and answer
    typedef struct packed {
        logic [15:0] addr;
    } sbp_lookup_req_t;

    typedef struct packed {
        logic       hit;
        logic [7:0] data;
    } sbp_lookup_rsp_t;

endpackage

// >>> sbp_table_rom.sv
// Constant table of the five parameter double words, registered byte read
`timescale 1ns/100ps

module sbp_table_rom (
    input  wire logic                     clock,
    input  wire logic                     nrst,
    input  wire sbp_pkg::sbp_lookup_req_t req,
    output sbp_pkg::sbp_lookup_rsp_t      rsp,
    output logic [31:0]                   density_word,
    output logic [31:0]                   quad_word,
    output logic [31:0]                   dual_word,
    output logic [31:0]                   mode_word,
    output logic [31:0]                   dual_all_word
);

    typedef struct packed {
        sbp_pkg::sbp_lookup_rsp_t rsp;
    } sbp_rom_state_t;

    sbp_rom_state_t state_reg;
    sbp_rom_state_t state_next;
    logic [7:0]     table_bytes [0:19];
    logic [15:0]    rel_addr;
    logic [4:0]     index;

    // Double words assembled from named fields
    assign density_word  = sbp_pkg::DENSITY_BITS;  // see R2
    // see R3, see R4, see R5, see R6, see R7, see R8, see R9, see R10
    assign quad_word     = {sbp_pkg::QUAD_OUT_OP, sbp_pkg::QUAD_OUT_MODE,
                            sbp_pkg::PLAIN_DUMMY, sbp_pkg::QUAD_IO_OP,
                            sbp_pkg::QUAD_IO_MODE, sbp_pkg::DEFAULT_DUMMY};
    assign dual_word     = {sbp_pkg::DUAL_IO_OP, sbp_pkg::DUAL_IO_MODE,
                            sbp_pkg::DEFAULT_DUMMY, sbp_pkg::DUAL_OUT_OP,
                            sbp_pkg::DUAL_OUT_MODE, sbp_pkg::PLAIN_DUMMY};
    assign mode_word     = {sbp_pkg::RSV8, sbp_pkg::RSV8, sbp_pkg::RSV8,
                            sbp_pkg::RSV3, sbp_pkg::FOUR_WIRE_OK,
                            sbp_pkg::RSV3, sbp_pkg::DUAL_ALL_OK};
    assign dual_all_word = {sbp_pkg::DUAL_ALL_OP, sbp_pkg::DUAL_ALL_MODE,
                            sbp_pkg::DUAL_ALL_DUMMY, sbp_pkg::RSV8, sbp_pkg::RSV8};

    // Little-endian byte view, one entry per table byte
    genvar g;
    generate
        for (g = 0; g < 20; g = g + 1)
        begin : g_bytes
            logic [159:0] flat;
            assign flat = {dual_all_word, mode_word, dual_word, quad_word, density_word};
            assign table_bytes[g] = flat[8*g +: 8];
        end
    endgenerate

    // Either window into the discovery space maps onto the same bytes
    always_comb
    begin
        state_next = state_reg;
        rel_addr   = req.addr - sbp_pkg::TABLE_BASE;  // see R1
        if (req.addr >= sbp_pkg::TABLE_BASE + 16'(sbp_pkg::TABLE_FIRST)
            && req.addr <= sbp_pkg::TABLE_BASE + 16'(sbp_pkg::TABLE_LAST))
        begin
            rel_addr = req.addr - sbp_pkg::TABLE_BASE;
        end
        else
        begin
            rel_addr = req.addr - sbp_pkg::LEGACY_BASE - sbp_pkg::LEGACY_SHIFT;  // see R11
        end
        index = rel_addr[4:0] - sbp_pkg::TABLE_FIRST;
        if (rel_addr[15:5] == 11'h000 && rel_addr[4:0] >= sbp_pkg::TABLE_FIRST
            && rel_addr[4:0] <= sbp_pkg::TABLE_LAST)
        begin
            state_next.rsp.hit  = 1'b1;
            state_next.rsp.data = table_bytes[index];
        end
        else
        begin
            state_next.rsp.hit  = 1'b0;
            state_next.rsp.data = 8'hFF;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign rsp = state_reg.rsp;

endmodule // sbp_table_rom

// >>> sbp_apb_if.sv
// Two-wait APB slave front end for the parameter table
`timescale 1ns/100ps

module sbp_apb_if (
    input  wire logic                   clock,
    input  wire logic                   nrst,
    input  wire sbp_pkg::sbp_apb_req_t  req,
    input  wire logic [31:0]            read_word,
    input  wire logic                   read_valid,
    output logic                        write_strobe,
    output sbp_pkg::sbp_apb_rsp_t       rsp
);

    typedef struct packed {
        logic                  waited;
        sbp_pkg::sbp_apb_rsp_t rsp;
    } sbp_apb_state_t;

    sbp_apb_state_t state_reg;
    sbp_apb_state_t state_next;

    // Two wait states so the registered table byte is ready in time
    always_comb
    begin
        state_next            = state_reg;
        state_next.rsp.pready = 1'b0;
        if (req.psel && req.penable && !state_reg.rsp.pready)
        begin
            if (state_reg.waited)
            begin
                state_next.rsp.pready  = 1'b1;
                state_next.rsp.pslverr = !read_valid;
                state_next.rsp.prdata  = req.pwrite ? sbp_pkg::ZERO_WORD : read_word;
                state_next.waited      = 1'b0;
            end
            else
            begin
                state_next.waited = 1'b1;
            end
        end
        else
        begin
            state_next.waited = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign rsp          = state_reg.rsp;
    assign write_strobe = req.psel && req.penable && req.pwrite && state_reg.rsp.pready;

endmodule // sbp_apb_if

// >>> sbp_checker.sv
// Concurrent checks on the APB answers of the parameter table
`timescale 1ns/100ps

module sbp_checker (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // Read answer qualifier; the master holds paddr through the answer
    logic rd;
    assign rd = pready && !pwrite;

    // Two wait states mean the access phase was already seen two cycles before the answer
    a_ready_wait: assert property (pready |-> psel && penable && $past(psel && penable, 2))
        else $error("answer without held access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_density_value: assert property (rd && paddr == 12'h004 |-> prdata == 32'h03FFFFFF)
        else $error("density word wrong");
    a_quad_fields: assert property (rd && paddr == 12'h008 |-> prdata ==
        {8'h6B, 3'h0, 5'h08, 8'hEB, 3'h2, 5'h08}) else $error("quad word wrong");
    a_dual_fields: assert property (rd && paddr == 12'h00C |-> prdata ==
        {8'hBB, 3'h4, 5'h08, 8'h3B, 3'h0, 5'h08}) else $error("dual word wrong");
    a_default_dummy: assert property (rd && paddr == 12'h008 |-> prdata[4:0] == 5'h08)
        else $error("quad io dummy not default");
    a_dual_io_dummy: assert property (rd && paddr == 12'h00C |-> prdata[20:16] == 5'h08)
        else $error("dual io dummy not default");
    a_mode_support: assert property (rd && paddr == 12'h010 |-> prdata == 32'hFFFFFFFE)
        else $error("mode support word wrong");
    a_dual_all_fill: assert property (rd && paddr == 12'h014 |-> prdata == 32'hFFFFFFFF)
        else $error("dual all word wrong");
    a_write_refused: assert property (pready && pwrite |-> pslverr == (paddr != 12'h018))
        else $error("write refusal wrong");
    a_unmapped_err: assert property (pready && (paddr > 12'h01C || paddr < 12'h004)
        |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");

    // Main scenarios
    c_refused: cover property (pready && pslverr);
    c_byte_hit: cover property (rd && paddr == 12'h01C && prdata[8]);
    c_ptr_write: cover property (pready && pwrite && !pslverr);
endmodule // sbp_checker

bind sbp_basic_param_table sbp_checker i_sbp_checker (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata));

// >>> sbp_host_model.sv
// APB master model standing in for the host controller
`timescale 1ns/100ps

module sbp_host_model (
    input wire logic        clock,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [11:0]     paddr,
    output logic [31:0]     pwdata
);
    // Idle bus at time zero
    initial
    begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // One transfer after g+1 idle cycles; the wait is bounded so a dead slave ends it
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input int g, output logic [31:0] r, output logic e, output logic to);
        int n;
        n = 0;
        repeat (g) @(posedge clock);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1 && n < 32)
        begin
            @(posedge clock);
            n++;
        end
        r = prdata;
        e = pslverr;
        to = (n >= 32);
        // Released lines show the inverse so stale values cannot pass
        psel <= 1'h0;
        penable <= 1'h0;
        pwrite <= ~w;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // sbp_host_model

// >>> sbp_basic_param_table_bench.sv
// Self-checking bench of the parameter table block
`timescale 1ns/100ps

module sbp_basic_param_table_bench;
    logic        clock;
    logic        nrst;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [15:0] ptr;
    int          mismatches, compares;
    // Pointer corners: both table ends, one past each, and below the base
    logic [15:0] corner [6] = '{16'h1090, 16'h1093, 16'h1094, 16'h10A7, 16'h10A8, 16'h108E};

    initial
    begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    sbp_basic_param_table i_sbp_basic_param_table (.clock(clock), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata));
    sbp_host_model i_sbp_host_model (.clock(clock), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));

    function automatic logic [31:0] next_rand(logic [31:0] x);
        return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    // Table words assembled field by field
    function automatic logic [31:0] word_of(logic [11:0] a);
        case (a)
            12'h004: return 32'h03FFFFFF;
            12'h008: return {8'h6B, 3'h0, 5'h08, 8'hEB, 3'h2, 5'h08};
            12'h00C: return {8'hBB, 3'h4, 5'h08, 8'h3B, 3'h0, 5'h08};
            12'h010: return {24'hFFFFFF, 3'h7, 1'h1, 3'h7, 1'h0};
            default: return {8'hFF, 3'h7, 5'h1F, 16'hFFFF};
        endcase
    endfunction

    // Expected {error, data}; byte view misses outside the table with FFh
    function automatic logic [32:0] exp_read(logic [11:0] a);
        logic [15:0] off;
        logic [31:0] w;
        off = ptr - 16'h1090;
        w = word_of({7'h0, off[4:2], 2'h0});
        if (a >= 12'h004 && a <= 12'h014) return {1'h0, word_of(a)};
        if (a == 12'h018) return {17'h0, ptr};
        if (a != 12'h01C) return {1'h1, 32'h0};
        if (ptr < 16'h1094 || ptr > 16'h10A7) return {25'h0, 8'hFF};
        return {24'h0, 1'h1, w[8 * off[1:0] +: 8]};
    endfunction

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(string name, logic [32:0] exp, logic [32:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer with its expectation
    task automatic rw(logic w, logic [11:0] a, logic [31:0] d);
        logic [31:0] r;
        logic        e, to;
        i_sbp_host_model.xfer(w, a, d, int'(seed[4:3]), r, e, to);
        if (to)
        begin
            mismatches++;
            report_and_stop();
        end
        else
        begin
            if (w)
                check("write error", {a != 12'h018, 32'h0}, {e, 32'h0});
            else
                check("read", exp_read(a), {e, r});
            if (w && a == 12'h018) ptr = d[15:0];
        end
    endtask

    initial
    begin
        nrst = 1'h0;
        seed = 32'hD11E;
        ptr = 16'h1094;
        repeat (8) @(posedge clock);
        nrst <= 1'h1;
        for (int a = 0; a <= 32; a += 4) rw(1'h0, 12'(a), 32'h0);
        rw(1'h1, 12'h004, 32'hFFFFFFFF);
        rw(1'h0, 12'h004, 32'h0);
        foreach (corner[i])
        begin
            rw(1'h1, 12'h018, {16'h0, corner[i]});
            rw(1'h0, 12'h01C, 32'h0);
        end
        // Reset in mid-run must bring the pointer back to its start value
        @(posedge clock);
        nrst <= 1'h0;
        repeat (2) @(posedge clock);
        nrst <= 1'h1;
        ptr = 16'h1094;
        rw(1'h0, 12'h018, 32'h0);
        rw(1'h0, 12'h01C, 32'h0);
        repeat (80)
        begin
            seed = next_rand(seed);
            if (seed[0]) rw(1'h1, 12'h018, {16'h0, 16'h108C + 16'(seed[10:5])});
            else rw(seed[1] & seed[2], {6'h0, seed[9:6], 2'h0}, seed);
        end
        report_and_stop();
    end
endmodule // sbp_basic_param_table_bench
